/* logic/cim_top.sv */
// clock input select with signal-loss, offset and lock-loss monitoring
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module cim_top import cim_pkg::*; (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // clock inputs and crystal reference, sampled
    input wire logic [NUM_IN-1:0] i_clock_input,
    input wire logic i_crystal_reference,
    // manual select pins
    input wire logic [1:0] i_sel_pins,
    // phase detector out of lock
    input wire logic i_pll_unlocked,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // pll control
    output logic [1:0] o_active_input,
    output logic o_holdover,
    output logic o_freerun,
    output logic o_hitless_en,
    output logic o_ramp_en,
    output logic o_outputs_en,
    // status pins
    output logic o_lock_loss_flag,
    output logic o_interrupt_out_n
);
    logic [31:0] ctrl;
    logic [31:0] inen;
    logic [31:0] prio;
    logic [31:0] sens;
    logic [31:0] thr;
    logic [SB_W-1:0] mask;
    logic [SB_W-1:0] sticky;
    logic [SB_W-1:0] live;
    logic [NUM_IN:0] signal_loss_flag;
    logic [NUM_IN:0] frequency_offset_flag;
    logic [CNT_W-1:0] wcnt [NUM_IN+1];
    logic [CNT_W-1:0] ref_cnt;
    logic [CNT_W-1:0] win_ctr;
    logic win_tick;
    logic [NUM_IN-1:0] valid;
    logic [NUM_IN-1:0] in_on;
    logic [1:0] best;
    logic any_valid;
    logic [1:0] man_sel;
    logic man_ok;
    logic src_ok;
    logic [1:0] next_active;
    cim_state_t state;
    cim_state_t next_state;
    logic [15:0] pull_ctr;
    logic acc;
    logic [NUM_IN:0] smp;
    logic [2:0] ref_sel;

    assign smp = {i_crystal_reference, i_clock_input};
    assign in_on = inen[NUM_IN-1:0];
    assign ref_sel = ctrl[CB_REF_LO +: 3];
    assign acc = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;

    // shared measurement window
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            win_ctr <= '0;
        end else if (win_tick) begin
            win_ctr <= '0;
        end else begin
            win_ctr <= win_ctr + 1'b1;
        end
    end
    assign win_tick = (win_ctr == CNT_W'(WIN_CYC - 1));

    // zero-ppm reference: crystal or one of the inputs
    always_comb begin
        if (ref_sel == REF_XTAL) begin
            ref_cnt = wcnt[NUM_IN];
        end else begin
            ref_cnt = wcnt[ref_sel[1:0] - 2'h1];
        end
    end

    // one monitor per input plus the crystal; crystal is loss-only
    generate
        for (genvar g = 0; g <= NUM_IN; g++) begin : g_mon
            logic mon_on;
            if (g < NUM_IN) begin : g_in
                assign mon_on = in_on[g] & inen[NUM_IN + g];
            end else begin : g_x
                assign mon_on = 1'b1;
            end
            cim_mon u_mon (
                .i_mclk(i_mclk),
                .i_sys_rst(i_sys_rst),
                .i_clk_smp(smp[g]),
                .i_win_tick(win_tick),
                .i_los_en(mon_on),
                .i_los_sens(sens[8*(g % NUM_IN) +: 8]),
                .i_ref_cnt(ref_cnt),
                .i_prec_thr(thr[CNT_W-1:0]),
                .i_fast_thr(thr[2*CNT_W-1:CNT_W]),
                .i_prec_en(~ctrl[CB_PREC_DIS] & (g < NUM_IN) & in_on[g % NUM_IN]),
                .i_fast_en(~ctrl[CB_FAST_DIS] & (g < NUM_IN) & in_on[g % NUM_IN]),
                .o_los(signal_loss_flag[g]),
                .o_oof(frequency_offset_flag[g]),
                .o_win_cnt(wcnt[g])
            );
        end
    endgenerate

    // validity and best candidate by priority, lower value wins, ties to lower index
    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            valid[i] = in_on[i] & ~signal_loss_flag[i] & ~frequency_offset_flag[i];
        end
        if (ctrl[CB_ZDM]) begin
            valid[NUM_IN-1] = 1'b0;
        end
        any_valid = |valid;
        best = 2'h0;
        for (int i = NUM_IN - 1; i >= 0; i--) begin
            if (valid[i] && (!valid[best] || prio[2*i +: 2] <= prio[2*best +: 2])) begin
                best = 2'(i);
            end
        end
    end

    // manual code: pins after reset, register when chosen
    always_comb begin
        man_sel = ctrl[CB_REGSEL] ? ctrl[CB_SEL_LO +: 2] : i_sel_pins;
        man_ok = in_on[man_sel] & ~signal_loss_flag[man_sel]
               & ~(ctrl[CB_ZDM] & (man_sel == SEL_RESERVED));
    end

    // active input choice
    always_comb begin
        next_active = o_active_input;
        src_ok = man_ok;
        if (!ctrl[CB_AUTO]) begin
            next_active = man_sel;
        end else begin
            src_ok = any_valid;
            if (ctrl[CB_REVERT] || !valid[o_active_input]) begin
                if (any_valid) begin
                    next_active = best;
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_active_input <= 2'h0;
        end else begin
            o_active_input <= next_active;
        end
    end

    // loop state: never locked stays free-run, lost source goes holdover
    always_comb begin
        case (state)
            ST_FREERUN: next_state = src_ok ? ST_TRACK : ST_FREERUN;
            ST_TRACK: next_state = src_ok ? ST_TRACK : ST_HOLDOVER;
            ST_HOLDOVER: next_state = src_ok ? ST_TRACK : ST_HOLDOVER;
            default: next_state = ST_FREERUN;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state <= ST_FREERUN;
            o_holdover <= 1'b0;
            o_freerun <= 1'b1;
        end else begin
            state <= next_state;
            o_holdover <= (next_state == ST_HOLDOVER);
            o_freerun <= (next_state == ST_FREERUN);
        end
    end

    // pull-in after a switch or a free-run or holdover exit keeps lock loss up
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pull_ctr <= 16'h0000;
        end else if ((next_active != o_active_input && state == ST_TRACK)
                     || (state != ST_TRACK && next_state == ST_TRACK)) begin
            pull_ctr <= 16'(PULLIN_CYC);
        end else if (pull_ctr != 16'h0000) begin
            pull_ctr <= pull_ctr - 16'h0001;
        end
    end

    // lock loss: unlocked, pulling in, or no source to follow
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_lock_loss_flag <= 1'b1;
        end else begin
            o_lock_loss_flag <= i_pll_unlocked | (pull_ctr != 16'h0000)
                              | (next_state != ST_TRACK);
        end
    end

    // pll steering; hitless and ramp each follow their own control bit
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_hitless_en <= 1'b0;
            o_ramp_en <= 1'b0;
            o_outputs_en <= 1'b0;
        end else begin
            o_hitless_en <= ctrl[CB_HITLESS];
            o_ramp_en <= ctrl[CB_RAMP];
            o_outputs_en <= ~signal_loss_flag[NUM_IN] | ctrl[CB_XKEEP];
        end
    end

    // live status
    assign live = {o_holdover, o_lock_loss_flag, signal_loss_flag[NUM_IN],
                   frequency_offset_flag[NUM_IN-1:0], signal_loss_flag[NUM_IN-1:0]};

    // sticky: a new event wins over a clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sticky <= '0;
        end else if (acc && i_avs_write && i_avs_address == OFS_STICKY) begin
            sticky <= (sticky & ~i_avs_writedata[SB_W-1:0]) | live;
        end else begin
            sticky <= sticky | live;
        end
    end

    // interrupt: any unmasked sticky bit, released when cleared
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_interrupt_out_n <= 1'b1;
        end else begin
            o_interrupt_out_n <= ~|(sticky & mask);
        end
    end

    // config writes take effect only on the accepted edge
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl <= CTRL_RST;
            inen <= INEN_RST;
            prio <= PRIO_RST;
            sens <= SENS_RST;
            thr <= THR_RST;
            mask <= MASK_RST;
        end else if (acc && i_avs_write) begin
            case (i_avs_address)
                OFS_CTRL: ctrl <= i_avs_writedata;
                OFS_INEN: inen <= i_avs_writedata;
                OFS_PRIO: prio <= i_avs_writedata;
                OFS_SENS: sens <= i_avs_writedata;
                OFS_THR: thr <= i_avs_writedata;
                OFS_MASK: mask <= i_avs_writedata[SB_W-1:0];
                default: ;
            endcase
        end
    end

    // one wait cycle, then one ready cycle per request
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                case (i_avs_address)
                    OFS_CTRL: o_avs_readdata <= ctrl;
                    OFS_INEN: o_avs_readdata <= inen;
                    OFS_PRIO: o_avs_readdata <= prio;
                    OFS_SENS: o_avs_readdata <= sens;
                    OFS_THR: o_avs_readdata <= thr;
                    OFS_LIVE: o_avs_readdata <= 32'({o_active_input, live});
                    OFS_STICKY: o_avs_readdata <= 32'(sticky);
                    OFS_MASK: o_avs_readdata <= 32'(mask);
                    default: o_avs_readdata <= RD_UNMAPPED;
                endcase
            end
        end
    end

    sequence s_switch;
        ##1 (o_active_input != $past(o_active_input)) && state == ST_TRACK;
    endsequence

    property p_pullin;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_switch |=> o_lock_loss_flag [*8];
    endproperty
    a_pullin: assert property (p_pullin) else $error("lock loss dropped during pull-in");

    property p_manual;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !ctrl[CB_AUTO] && !ctrl[CB_REGSEL] |=> o_active_input == $past(i_sel_pins);
    endproperty
    a_manual: assert property (p_manual) else $error("manual pin select not followed");

    property p_zdm;
        @(posedge i_mclk) disable iff (i_sys_rst)
        ctrl[CB_ZDM] && !ctrl[CB_AUTO] && man_sel == SEL_RESERVED && state == ST_TRACK
        |=> !o_freerun ##0 o_holdover;
    endproperty
    a_zdm: assert property (p_zdm) else $error("reserved code did not drop to holdover");

    property p_auto_hold;
        @(posedge i_mclk) disable iff (i_sys_rst)
        ctrl[CB_AUTO] && !any_valid && state == ST_TRACK |=> o_holdover;
    endproperty
    a_auto_hold: assert property (p_auto_hold) else $error("no holdover with no valid input");

    property p_revert;
        @(posedge i_mclk) disable iff (i_sys_rst)
        ctrl[CB_AUTO] && ctrl[CB_REVERT] && any_valid |=> o_active_input == $past(best);
    endproperty
    a_revert: assert property (p_revert) else $error("revertive choice not best input");

    property p_nonrevert;
        @(posedge i_mclk) disable iff (i_sys_rst)
        ctrl[CB_AUTO] && !ctrl[CB_REVERT] && valid[o_active_input] |=> $stable(o_active_input);
    endproperty
    a_nonrevert: assert property (p_nonrevert) else $error("non-revertive switched valid input");

    property p_xtal;
        @(posedge i_mclk) disable iff (i_sys_rst)
        signal_loss_flag[NUM_IN] && !ctrl[CB_XKEEP] |=> !o_outputs_en;
    endproperty
    a_xtal: assert property (p_xtal) else $error("outputs kept on crystal loss");

    property p_sticky;
        @(posedge i_mclk) disable iff (i_sys_rst)
        live[SB_XLOS] |=> sticky[SB_XLOS];
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky flag lost an event");

    property p_irq;
        @(posedge i_mclk) disable iff (i_sys_rst)
        |(sticky & mask) |=> !o_interrupt_out_n;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not asserted");

    property p_bus;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule // cim_top

/* logic/cim_pkg.sv */
// shared constants for the clock input select and fault monitor block
package cim_pkg;
    localparam int NUM_IN = 4;
    localparam int CNT_W = 16;
    // timing: clock period and derived cycle counts
    localparam int CLK_PERIOD_NS = 10;
    localparam int WIN_TIME_NS = 10240;
    localparam int WIN_CYC = WIN_TIME_NS / CLK_PERIOD_NS;
    localparam int PULLIN_TIME_NS = 10000;
    localparam int PULLIN_CYC = PULLIN_TIME_NS / CLK_PERIOD_NS;
    // register word offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_INEN = 4'h1;
    localparam logic [3:0] OFS_PRIO = 4'h2;
    localparam logic [3:0] OFS_SENS = 4'h3;
    localparam logic [3:0] OFS_THR = 4'h4;
    localparam logic [3:0] OFS_LIVE = 4'h5;
    localparam logic [3:0] OFS_STICKY = 4'h6;
    localparam logic [3:0] OFS_MASK = 4'h7;
    // control register fields
    localparam int CB_AUTO = 0;
    localparam int CB_REGSEL = 1;
    localparam int CB_SEL_LO = 2;
    localparam int CB_ZDM = 4;
    localparam int CB_REVERT = 5;
    localparam int CB_HITLESS = 6;
    localparam int CB_RAMP = 7;
    localparam int CB_XKEEP = 8;
    localparam int CB_REF_LO = 9;
    localparam int CB_PREC_DIS = 12;
    localparam int CB_FAST_DIS = 13;
    // status bit positions (live and sticky share all but SB_ACT, which only the live read holds)
    localparam int SB_LOS = 0;
    localparam int SB_OOF = 4;
    localparam int SB_XLOS = 8;
    localparam int SB_LOL = 9;
    localparam int SB_HOLD = 10;
    localparam int SB_W = 11;
    localparam int SB_ACT = 11;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_00A0;
    localparam logic [31:0] INEN_RST = 32'h0000_00FF;
    localparam logic [31:0] PRIO_RST = 32'h0000_00E4;
    localparam logic [31:0] SENS_RST = 32'h1010_1010;
    localparam logic [31:0] THR_RST = 32'h0040_0004;
    localparam logic [SB_W-1:0] MASK_RST = 11'h000;
    localparam logic [2:0] REF_XTAL = 3'h0;
    localparam logic [1:0] SEL_RESERVED = 2'h3;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    // operating states of the loop, one-hot
    typedef enum logic [2:0] {
        ST_FREERUN = 3'b001,
        ST_TRACK = 3'b010,
        ST_HOLDOVER = 3'b100
    } cim_state_t;
    // magnitude of a difference between two counts
    function automatic logic [CNT_W-1:0] cim_absdiff(input logic [CNT_W-1:0] a,
                                                    input logic [CNT_W-1:0] b);
        cim_absdiff = (a > b) ? (a - b) : (b - a);
    endfunction
endpackage

/* logic/cim_mon.sv */
// per-clock signal-loss and frequency-offset monitor
`timescale 1ns/1ps
module cim_mon import cim_pkg::*; (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // monitored clock and window
    input wire logic i_clk_smp,
    input wire logic i_win_tick,
    // configuration
    input wire logic i_los_en,
    input wire logic [7:0] i_los_sens,
    input wire logic [CNT_W-1:0] i_ref_cnt,
    input wire logic [CNT_W-1:0] i_prec_thr,
    input wire logic [CNT_W-1:0] i_fast_thr,
    input wire logic i_prec_en,
    input wire logic i_fast_en,
    // results
    output logic o_los,
    output logic o_oof,
    output logic [CNT_W-1:0] o_win_cnt
);
    logic prev;
    logic [7:0] gap;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last_cnt;
    logic [1:0] full;
    logic rise;

    assign rise = i_clk_smp & ~prev;

    // period watch: cycles since the last rising edge, saturating
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            prev <= 1'b0;
            gap <= 8'h00;
        end else begin
            prev <= i_clk_smp;
            if (rise) begin
                gap <= 8'h00;
            end else if (gap != 8'hFF) begin
                gap <= gap + 8'h01;
            end
        end
    end

    // loss only once the gap exceeds the sensitivity, so short gaps pass
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_los <= 1'b0;
        end else begin
            o_los <= i_los_en & (gap > i_los_sens);
        end
    end

    // edge count per window; last window kept for the fast check
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cnt <= '0;
            o_win_cnt <= '0;
            last_cnt <= '0;
            full <= 2'h0;
        end else if (i_win_tick) begin
            cnt <= {{(CNT_W-1){1'b0}}, rise};
            o_win_cnt <= cnt;
            last_cnt <= o_win_cnt;
            full <= {full[0], 1'b1}; // marks whole windows held in both stores
        end else if (rise) begin
            cnt <= cnt + 1'b1;
        end
    end

    // precise against reference, fast against own previous window
    // fast waits for two whole windows, else the empty store reads as a jump
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_oof <= 1'b0;
        end else begin
            o_oof <= (i_prec_en & (cim_absdiff(o_win_cnt, i_ref_cnt) > i_prec_thr))
                   | (i_fast_en & full[1]
                      & (cim_absdiff(o_win_cnt, last_cnt) > i_fast_thr));
        end
    end

    property p_los_gap;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (i_los_en && gap > i_los_sens) |=> o_los;
    endproperty
    a_los_gap: assert property (p_los_gap) else $error("signal loss not raised on long gap");

    property p_los_dis;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !i_los_en |=> !o_los;
    endproperty
    a_los_dis: assert property (p_los_dis) else $error("disabled monitor raised loss");
endmodule // cim_mon

/* testbench/cim_src.sv */
// model of the upstream clock sources and crystal reference
`timescale 1ns/1ps
module cim_src (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // per-source run enables
    input wire logic [3:0] i_run,
    input wire logic i_xtal_run,
    // sampled clock levels
    output logic [3:0] o_clock_input,
    output logic o_crystal_reference
);
    logic ph;
    // period of four mclk cycles, 25 MHz, no gaps
    // a stopped source stands still low, as a dead input would
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ph <= 1'b0;
            o_clock_input <= 4'h0;
            o_crystal_reference <= 1'b0;
        end else begin
            ph <= ~ph;
            o_clock_input <= i_run & (ph ? ~o_clock_input : o_clock_input);
            o_crystal_reference <= i_xtal_run & (ph ? ~o_crystal_reference : o_crystal_reference);
        end
    end
endmodule // cim_src

/* testbench/cim_top_tb.sv */
// self-checking bench for the clock input selector
`timescale 1ns/1ps
module cim_top_tb import cim_pkg::*;;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] clock_input;
    logic crystal_reference;
    logic [3:0] run = 4'hF;
    logic xtal_run = 1'b1;
    logic [1:0] sel_pins = 2'h0;
    logic pll_unlocked = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] active_input;
    logic holdover, freerun, hitless_en, ramp_en, outputs_en, lock_loss, int_n;
    logic [31:0] q;
    int n_errors = 0;
    int checks = 0;

    cim_src cim_src_inst (.i_mclk(i_mclk), .i_rst(i_sys_rst), .i_run(run), .i_xtal_run(xtal_run),
        .o_clock_input(clock_input), .o_crystal_reference(crystal_reference));
    cim_top cim_top_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_clock_input(clock_input), .i_crystal_reference(crystal_reference),
        .i_sel_pins(sel_pins), .i_pll_unlocked(pll_unlocked),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
        .o_avs_waitrequest(avs_waitrequest), .o_active_input(active_input),
        .o_holdover(holdover), .o_freerun(freerun), .o_hitless_en(hitless_en),
        .o_ramp_en(ramp_en), .o_outputs_en(outputs_en), .o_lock_loss_flag(lock_loss),
        .o_interrupt_out_n(int_n));

    // 100 MHz clock
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge i_mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        check("bus latency", n, 32'h2);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic t_regs();
        bus(0, OFS_CTRL, 0); check("ctrl reset", q, 32'h0000_00A0);
        bus(0, OFS_INEN, 0); check("inen reset", q, 32'h0000_00FF);
        bus(0, OFS_PRIO, 0); check("prio reset", q, 32'h0000_00E4);
        bus(0, 4'hC, 0); check("unmapped read", q, 32'h0);
        $display("done regs");
    endtask

    task automatic t_manual();
        for (int c = 0; c < 4; c++) begin
            sel_pins <= c[1:0];
            wt(100);
            check("pin select", active_input, c[1:0]);
        end
        bus(1, OFS_CTRL, 32'h0000_00AA); wt(100);
        check("register select", active_input, 2'h2);
        bus(1, OFS_CTRL, 32'h0000_00B0); wt(100);
        check("zero delay code 3", holdover, 1'b1);
        bus(1, OFS_CTRL, 32'h0000_00A0);
        $display("done manual");
    endtask

    task automatic t_loss();
        sel_pins <= 2'h1;
        bus(1, OFS_MASK, 32'h2);
        run <= 4'hD; wt(200);
        check("no clock holdover", holdover, 1'b1);
        check("lock loss untracked", lock_loss, 1'b1);
        bus(0, OFS_LIVE, 0); check("live loss", q[1], 1'b1);
        check("interrupt low", int_n, 1'b0);
        run <= 4'hF; wt(200);
        bus(0, OFS_LIVE, 0); check("live loss gone", q[1], 1'b0);
        bus(0, OFS_STICKY, 0); check("sticky held", q[1], 1'b1);
        bus(1, OFS_STICKY, 32'h2);
        bus(0, OFS_STICKY, 0); check("sticky cleared", q[1], 1'b0);
        wt(4); check("interrupt released", int_n, 1'b1);
        bus(1, OFS_INEN, 32'h0000_00DF); run <= 4'hD; wt(200);
        bus(0, OFS_LIVE, 0); check("loss monitor off", q[1], 1'b0);
        run <= 4'hF; bus(1, OFS_INEN, 32'h0000_00FF); bus(1, OFS_MASK, 0);
        wt(2 * WIN_CYC + 16); // stopped input skews two offset windows
        $display("done loss");
    endtask

    task automatic t_auto();
        bus(1, OFS_CTRL, 32'h0000_0021); wt(200);
        check("auto best", active_input, 2'h0);
        bus(0, OFS_LIVE, 0); check("offset clear", q[7:4], 4'h0);
        bus(0, OFS_STICKY, 0); check("offset sticky idle", q[4], 1'b0);
        run <= 4'hE; wt(200);
        check("auto fail over", active_input, 2'h1);
        run <= 4'hF; wt(4000);
        check("revert", active_input, 2'h0);
        bus(0, OFS_STICKY, 0); check("offset sticky", q[4], 1'b1);
        bus(0, OFS_LIVE, 0); check("offset live gone", q[4], 1'b0);
        bus(1, OFS_CTRL, 32'h0000_0001);
        run <= 4'hE; wt(200); run <= 4'hF; wt(4000);
        check("non revert", active_input, 2'h1);
        bus(1, OFS_INEN, 32'h0000_00FD); wt(200);
        check("disabled input left", active_input, 2'h0);
        bus(1, OFS_INEN, 32'h0000_00FF);
        run <= 4'h0; wt(200);
        check("none valid", holdover, 1'b1);
        run <= 4'hF; bus(1, OFS_CTRL, 32'h0000_00A0); sel_pins <= 2'h0; wt(200);
        $display("done auto");
    endtask

    task automatic t_misc();
        wt(1100);
        check("locked", lock_loss, 1'b0);
        pll_unlocked <= 1'b1; wt(10);
        check("lock lost", lock_loss, 1'b1);
        pll_unlocked <= 1'b0;
        bus(1, OFS_CTRL, 32'h0000_00E0); wt(4);
        check("hitless on", {hitless_en, ramp_en}, 2'h3);
        bus(1, OFS_CTRL, 32'h0000_0020); wt(4);
        check("hitless off", {hitless_en, ramp_en}, 2'h0);
        xtal_run <= 1'b0; wt(200);
        check("outputs stopped", outputs_en, 1'b0);
        bus(0, OFS_LIVE, 0); check("crystal loss", q[8], 1'b1);
        bus(1, OFS_CTRL, 32'h0000_0120); wt(4);
        check("outputs kept", outputs_en, 1'b1);
        xtal_run <= 1'b1;
        $display("done misc");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // hang guard, well beyond the expected run length
    initial begin
        wt(60000);
        n_errors++;
        summarize();
    end

    initial begin
        wt(4);
        check("freerun in reset", freerun, 1'b1);
        check("interrupt idle", int_n, 1'b1);
        wt(12);
        i_sys_rst <= 1'b0;
        wt(1);
        t_regs();
        t_manual();
        t_loss();
        t_auto();
        t_misc();
        summarize();
    end
endmodule // cim_top_tb
